//--- rtl/vic_defines.svh
// Constants of the vectored interrupt controller
// Notes on behaviour
// - Two external inputs are active low, level or falling edge by type bit
// - In edge mode the external pending flag clears when the core vectors
// - In level mode the external pending flag mirrors the synchronised pin
// - Reset vector 0x0000; sources 0..5 vector 0x0003 onward in steps of 8
// - Sources 6..12, 14 and 15 vector 0x0033..0x007B in fixed order
// - Sources 16..20 vector 0x0083, 0x0093, 0x008B, 0x009B, 0x00A3
// - External, timer 0/1 and CAN flags clear on vectoring; others by software
// - Sources with several flags request when any of their flags is set
// - With auto page switching on, vectoring loads the source's register page
// - High level preempts a low routine; nothing preempts a high routine
// - One priority bit per source, 1 high, all low after reset
// - Higher level wins, then the lowest fixed order number
// - Pending enabled requests are sampled and resolved every clock
// - Response is one detect clock plus four call clocks at the least
// - After a return with a request pending one more instruction completes
// - Worst response is 18 clocks: detect, return, divide and call
// - Equal or higher routine running blocks until return plus one instruction
// - Global enable gates every source; each also needs its own enable
// - Flags set regardless of enables; a software 1 requests like hardware, except on an external source in level mode
// - An accepted request waits for the instruction end, then calls the vector
// - A flag still set after return requests again after the next instruction
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// Register offsets on the plain register port
`define VIC_OFS_TCTL      8'h88
`define VIC_OFS_PAGE      8'h84
`define VIC_OFS_PGCTL     8'h8f
`define VIC_OFS_ENA_MAIN  8'ha8
`define VIC_OFS_PRI_MAIN  8'hb8
`define VIC_OFS_ENA_ONE   8'he6
`define VIC_OFS_ENA_TWO   8'he7
`define VIC_OFS_PRI_ONE   8'hf6
`define VIC_OFS_PRI_TWO   8'hf7
`define VIC_OFS_PEND_LO   8'hd8
`define VIC_OFS_PEND_MID  8'hd9
`define VIC_OFS_PEND_HI   8'hda
`define VIC_OFS_STATUS    8'hdb

// Field positions
`define VIC_TC_TYPE0      0
`define VIC_TC_PEND0      1
`define VIC_TC_TYPE1      2
`define VIC_TC_PEND1      3
`define VIC_TC_TOV0       5
`define VIC_TC_TOV1       7
`define VIC_IE_GLOBAL     7
`define VIC_IE_SPARE      6
`define VIC_PGCTL_AUTO    0

// Reset and fixed read values
`define VIC_RST_BYTE      8'h00
`define VIC_PRI_MAIN_ONES 8'hc0
`define VIC_RSVD_MASK     8'h7f

// Source indexes in fixed priority order
`define VIC_SRC_EXT0      5'h00
`define VIC_SRC_T0        5'h01
`define VIC_SRC_EXT1      5'h02
`define VIC_SRC_T1        5'h03
`define VIC_SRC_CMP0      5'h0a
`define VIC_SRC_CMP1      5'h0b
`define VIC_SRC_CMP2      5'h0c
`define VIC_SRC_T3        5'h0e
`define VIC_SRC_T4        5'h10
`define VIC_SRC_CV2_WIN   5'h11
`define VIC_SRC_CV2_EOC   5'h12
`define VIC_SRC_CAN       5'h13
`define VIC_SRC_SER1      5'h14
`define VIC_NSRC          21

// Vector addresses
`define VIC_VEC_RESET     16'h0000
`define VIC_VEC_BASE      16'h0003
`define VIC_VEC_SHIFT     3
`define VIC_VEC_CV2_WIN   16'h0093
`define VIC_VEC_CV2_EOC   16'h008b

// Register pages
`define VIC_PAGE_ZERO     8'h00
`define VIC_PAGE_ONE      8'h01
`define VIC_PAGE_TWO      8'h02
`define VIC_PAGE_THREE    8'h03

// Timing in system clocks
`define VIC_DETECT_CLKS   1
`define VIC_CALL_CLKS     4
`define VIC_CALL_LAST     2'h3

`endif

//--- rtl/vic_pkg.sv
// Types of the vectored interrupt controller
package vic_pkg;

  // Sequencer states of the forced call
  typedef enum logic [0:0] {
    VIC_IDLE = 1'b0,
    VIC_CALL = 1'b1
  } vic_state_e;

  // Instruction boundary events from the core sequencer
  typedef struct packed {
    logic instr_done;  // An instruction completes this cycle
    logic reti_done;   // The completing instruction is a return
  } vic_core_s;

  // Pending flag levels held inside the peripherals
  typedef struct packed {
    logic [1:0] serial_one;
    logic       conv_two_eoc;
    logic       conv_two_win;
    logic       timer_four;
    logic       conv_zero_eoc;
    logic       timer_three;
    logic [1:0] comparator_two;
    logic [1:0] comparator_one;
    logic [1:0] comparator_zero;
    logic [6:0] counter_array;
    logic       conv_zero_win;
    logic       two_wire;
    logic [3:0] serial_periph;
    logic       timer_two;
    logic [1:0] serial_zero;
  } vic_flags_s;

  // Single-cycle set events for flags held here
  typedef struct packed {
    logic can_event;
    logic timer_one_ovf;
    logic timer_zero_ovf;
  } vic_events_s;

endpackage : vic_pkg

//--- rtl/vic_top.sv
// Vectored two-level interrupt controller beside the core sequencer
`timescale 1ns/1ns
`include "vic_defines.svh"

module vic_top
  import vic_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  // External request pins
  input  wire logic        ext_request_zero_n_i,
  input  wire logic        ext_request_one_n_i,
  // Peripheral flags and events
  input  wire vic_flags_s  periph_flags_i,
  input  wire vic_events_s periph_events_i,
  // Core sequencer
  input  wire vic_core_s   core_i,
  output logic             call_active_o,
  output logic             vector_valid_o,
  output logic      [15:0] vector_o,
  output logic      [7:0]  register_page_select_o
);

  // Lowest set index of a request vector
  function automatic logic [4:0] pick_first(input logic [20:0] req);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
      if (req[i]) idx = 5'(i);
    end
    return idx;
  endfunction : pick_first

  // Vector address of a source
  function automatic logic [15:0] vec_of(input logic [4:0] src);
    logic [15:0] v;
    v = `VIC_VEC_BASE + (16'(src) << `VIC_VEC_SHIFT);
    if (src == `VIC_SRC_CV2_WIN) v = `VIC_VEC_CV2_WIN;
    if (src == `VIC_SRC_CV2_EOC) v = `VIC_VEC_CV2_EOC;
    return v;
  endfunction : vec_of

  // Register page of a source
  function automatic logic [7:0] page_of(input logic [4:0] src);
    logic [7:0] p;
    p = `VIC_PAGE_ZERO;
    if (src == `VIC_SRC_CMP0 || src == `VIC_SRC_T3 ||
        src == `VIC_SRC_CAN  || src == `VIC_SRC_SER1) p = `VIC_PAGE_ONE;
    if (src == `VIC_SRC_CMP1 || src == `VIC_SRC_T4 ||
        src == `VIC_SRC_CV2_WIN || src == `VIC_SRC_CV2_EOC) begin
      p = `VIC_PAGE_TWO;
    end
    if (src == `VIC_SRC_CMP2) p = `VIC_PAGE_THREE;
    return p;
  endfunction : page_of

  // Software-visible registers
  logic [7:0]  timer_control_reg;
  logic [7:0]  interrupt_enable_main;
  logic [5:0]  interrupt_priority_main;
  logic [6:0]  extended_enable_one;
  logic [6:0]  extended_enable_two;
  logic [6:0]  extended_priority_one;
  logic [6:0]  extended_priority_two;
  logic        auto_page_switch_enable;
  logic [20:0] flags;

  // Sequencing state
  vic_state_e  state;
  logic [1:0]  call_cnt;
  logic [4:0]  cur_src;
  logic        cur_hi;
  logic        in_svc_lo;
  logic        in_svc_hi;
  logic        post_reti;
  logic        det_valid;
  logic        det_hi;
  logic [4:0]  det_src;

  // Pin synchronisers
  logic [1:0]  ext0_sync;
  logic [1:0]  ext1_sync;
  logic        ext0_prev;
  logic        ext1_prev;

  // Combinational view
  logic [20:0] pend_eff;
  logic [20:0] enables;
  logic [20:0] priorities;
  logic [20:0] req;
  logic [20:0] req_hi;
  logic        ext0_fall;
  logic        ext1_fall;
  logic        type0_edge;
  logic        type1_edge;
  logic        accept;
  logic [20:0] hw_clear;
  logic [20:0] hw_set;

  // Two flops on each external pin before any logic reads it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext0_sync <= 2'h3;
      ext1_sync <= 2'h3;
      ext0_prev <= 1'b1;
      ext1_prev <= 1'b1;
    end else if (ce_i) begin
      ext0_sync <= {ext0_sync[0], ext_request_zero_n_i};
      ext1_sync <= {ext1_sync[0], ext_request_one_n_i};
      ext0_prev <= ext0_sync[1];
      ext1_prev <= ext1_sync[1];
    end
  end

  // Falling edge detection on the synchronised pins
  assign type0_edge = timer_control_reg[`VIC_TC_TYPE0];
  assign type1_edge = timer_control_reg[`VIC_TC_TYPE1];
  assign ext0_fall  = ext0_prev & ~ext0_sync[1];
  assign ext1_fall  = ext1_prev & ~ext1_sync[1];

  // Effective pending flags per source
  always_comb begin
    pend_eff = flags;
    pend_eff[`VIC_SRC_EXT0] = type0_edge ? flags[`VIC_SRC_EXT0]
                                         : ~ext0_sync[1];
    pend_eff[`VIC_SRC_EXT1] = type1_edge ? flags[`VIC_SRC_EXT1]
                                         : ~ext1_sync[1];
    pend_eff[4]  = flags[4]  | (|periph_flags_i.serial_zero);
    pend_eff[5]  = flags[5]  | periph_flags_i.timer_two;
    pend_eff[6]  = flags[6]  | (|periph_flags_i.serial_periph);
    pend_eff[7]  = flags[7]  | periph_flags_i.two_wire;
    pend_eff[8]  = flags[8]  | periph_flags_i.conv_zero_win;
    pend_eff[9]  = flags[9]  | (|periph_flags_i.counter_array);
    pend_eff[10] = flags[10] | (|periph_flags_i.comparator_zero);
    pend_eff[11] = flags[11] | (|periph_flags_i.comparator_one);
    pend_eff[12] = flags[12] | (|periph_flags_i.comparator_two);
    pend_eff[13] = 1'b0;  // Order slot 13 has no source
    pend_eff[14] = flags[14] | periph_flags_i.timer_three;
    pend_eff[15] = flags[15] | periph_flags_i.conv_zero_eoc;
    pend_eff[16] = flags[16] | periph_flags_i.timer_four;
    pend_eff[17] = flags[17] | periph_flags_i.conv_two_win;
    pend_eff[18] = flags[18] | periph_flags_i.conv_two_eoc;
    pend_eff[20] = flags[20] | (|periph_flags_i.serial_one);
  end

  // Enable and priority bits gathered in fixed order
  assign enables    = {extended_enable_two, 1'b0, extended_enable_one,
                       interrupt_enable_main[5:0]};
  assign priorities = {extended_priority_two, 1'b0, extended_priority_one,
                       interrupt_priority_main};
  assign req    = interrupt_enable_main[`VIC_IE_GLOBAL] ?
                  (pend_eff & enables) : '0;
  assign req_hi = req & priorities;

  // Detect stage resolves priority every clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      det_valid <= 1'b0;
      det_hi    <= 1'b0;
      det_src   <= 5'h00;
    end else if (ce_i) begin
      det_valid <= |req;
      det_hi    <= |req_hi;
      det_src   <= (|req_hi) ? pick_first(req_hi)
                             : pick_first(req);
    end
  end

  // Take a request at an instruction boundary unless blocked
  assign accept = ce_i && state == VIC_IDLE && det_valid &&
                  core_i.instr_done && !core_i.reti_done &&
                  !post_reti && !in_svc_hi &&
                  (det_hi || !in_svc_lo);

  // Hardware set and clear masks for flags held here
  always_comb begin
    hw_set   = '0;
    hw_clear = '0;
    hw_set[`VIC_SRC_EXT0] = ext0_fall & type0_edge;
    hw_set[`VIC_SRC_EXT1] = ext1_fall & type1_edge;
    hw_set[`VIC_SRC_T0]   = periph_events_i.timer_zero_ovf;
    hw_set[`VIC_SRC_T1]   = periph_events_i.timer_one_ovf;
    hw_set[`VIC_SRC_CAN]  = periph_events_i.can_event;
    if (accept && (det_src == `VIC_SRC_EXT0 || det_src == `VIC_SRC_EXT1 ||
                   det_src == `VIC_SRC_T0 || det_src == `VIC_SRC_T1 ||
                   det_src == `VIC_SRC_CAN)) begin
      hw_clear[det_src] = 1'b1;
    end
  end

  // Pending flags: software writes, hardware clear, set wins last
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else if (ce_i) begin
      logic [20:0] f;
      f = flags;
      if (reg_we_i && reg_addr_i == `VIC_OFS_TCTL) begin
        f[`VIC_SRC_EXT0] = reg_wdata_i[`VIC_TC_PEND0];
        f[`VIC_SRC_EXT1] = reg_wdata_i[`VIC_TC_PEND1];
        f[`VIC_SRC_T0]   = reg_wdata_i[`VIC_TC_TOV0];
        f[`VIC_SRC_T1]   = reg_wdata_i[`VIC_TC_TOV1];
      end
      if (reg_we_i && reg_addr_i == `VIC_OFS_PEND_LO) f[7:0] = reg_wdata_i;
      if (reg_we_i && reg_addr_i == `VIC_OFS_PEND_MID) f[15:8] = reg_wdata_i;
      if (reg_we_i && reg_addr_i == `VIC_OFS_PEND_HI) begin
        f[20:16] = reg_wdata_i[4:0];
      end
      f = (f & ~hw_clear) | hw_set;
      f[13] = 1'b0;
      flags <= f;
    end
  end

  // Control registers written by software
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      timer_control_reg       <= `VIC_RST_BYTE;
      interrupt_enable_main   <= `VIC_RST_BYTE;
      interrupt_priority_main <= 6'h00;
      extended_enable_one     <= 7'h00;
      extended_enable_two     <= 7'h00;
      extended_priority_one   <= 7'h00;
      extended_priority_two   <= 7'h00;
      auto_page_switch_enable <= 1'b0;
    end else if (ce_i && reg_we_i) begin
      unique case (reg_addr_i)
        `VIC_OFS_TCTL:     timer_control_reg       <= reg_wdata_i;
        `VIC_OFS_ENA_MAIN: interrupt_enable_main   <= reg_wdata_i;
        `VIC_OFS_PRI_MAIN: interrupt_priority_main <= reg_wdata_i[5:0];
        `VIC_OFS_ENA_ONE:  extended_enable_one     <= reg_wdata_i[6:0];
        `VIC_OFS_ENA_TWO:  extended_enable_two     <= reg_wdata_i[6:0];
        `VIC_OFS_PRI_ONE:  extended_priority_one   <= reg_wdata_i[6:0];
        `VIC_OFS_PRI_TWO:  extended_priority_two   <= reg_wdata_i[6:0];
        `VIC_OFS_PGCTL:    auto_page_switch_enable <=
                             reg_wdata_i[`VIC_PGCTL_AUTO];
        default: ;
      endcase
    end
  end

  // Forced call sequencer and vector output
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state          <= VIC_IDLE;
      call_cnt       <= 2'h0;
      cur_src        <= 5'h00;
      cur_hi         <= 1'b0;
      call_active_o  <= 1'b0;
      vector_valid_o <= 1'b0;
      vector_o       <= `VIC_VEC_RESET;
    end else if (ce_i) begin
      vector_valid_o <= 1'b0;
      unique case (state)
        VIC_IDLE: begin
          if (accept) begin
            state         <= VIC_CALL;
            call_cnt      <= `VIC_CALL_LAST;
            cur_src       <= det_src;
            cur_hi        <= det_hi;
            call_active_o <= 1'b1;
          end
        end
        VIC_CALL: begin
          if (call_cnt == 2'h0) begin
            state          <= VIC_IDLE;
            call_active_o  <= 1'b0;
            vector_valid_o <= 1'b1;
            vector_o       <= vec_of(cur_src);
          end else begin
            call_cnt <= call_cnt - 2'h1;
          end
        end
      endcase
    end
  end

  // Register page loaded on vectoring or written by software
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      register_page_select_o <= `VIC_PAGE_ZERO;
    end else if (ce_i) begin
      if (state == VIC_CALL && call_cnt == 2'h0 && auto_page_switch_enable)
        register_page_select_o <= page_of(cur_src);
      else if (reg_we_i && reg_addr_i == `VIC_OFS_PAGE)
        register_page_select_o <= reg_wdata_i;
    end
  end

  // In-service levels and the one-instruction hold after a return
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      in_svc_lo <= 1'b0;
      in_svc_hi <= 1'b0;
      post_reti <= 1'b0;
    end else if (ce_i) begin
      if (core_i.instr_done && core_i.reti_done) begin
        post_reti <= 1'b1;
        if (in_svc_hi) in_svc_hi <= 1'b0;
        else in_svc_lo <= 1'b0;
      end else if (core_i.instr_done) begin
        post_reti <= 1'b0;
      end
      if (accept && det_hi) in_svc_hi <= 1'b1;
      if (accept && !det_hi) in_svc_lo <= 1'b1;
    end
  end

  // Read data stand one cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `VIC_RST_BYTE;
    end else if (ce_i) begin
      reg_rdata_o <= `VIC_RST_BYTE;
      if (reg_re_i) begin
        unique case (reg_addr_i)
          `VIC_OFS_TCTL: begin
            reg_rdata_o <= timer_control_reg;
            reg_rdata_o[`VIC_TC_PEND0] <= pend_eff[`VIC_SRC_EXT0];
            reg_rdata_o[`VIC_TC_PEND1] <= pend_eff[`VIC_SRC_EXT1];
            reg_rdata_o[`VIC_TC_TOV0]  <= flags[`VIC_SRC_T0];
            reg_rdata_o[`VIC_TC_TOV1]  <= flags[`VIC_SRC_T1];
          end
          `VIC_OFS_ENA_MAIN: reg_rdata_o <= interrupt_enable_main;
          `VIC_OFS_PRI_MAIN: reg_rdata_o <= `VIC_PRI_MAIN_ONES |
                                {2'h0, interrupt_priority_main};
          `VIC_OFS_ENA_ONE:  reg_rdata_o <= {1'b0, extended_enable_one};
          `VIC_OFS_ENA_TWO:  reg_rdata_o <= {1'b0, extended_enable_two};
          `VIC_OFS_PRI_ONE:  reg_rdata_o <= {1'b0, extended_priority_one};
          `VIC_OFS_PRI_TWO:  reg_rdata_o <= {1'b0, extended_priority_two};
          `VIC_OFS_PGCTL:    reg_rdata_o <= {7'h00, auto_page_switch_enable};
          `VIC_OFS_PAGE:     reg_rdata_o <= register_page_select_o;
          `VIC_OFS_PEND_LO:  reg_rdata_o <= pend_eff[7:0];
          `VIC_OFS_PEND_MID: reg_rdata_o <= pend_eff[15:8];
          `VIC_OFS_PEND_HI:  reg_rdata_o <= {3'h0, pend_eff[20:16]};
          `VIC_OFS_STATUS:   reg_rdata_o <= {in_svc_hi, in_svc_lo,
                                             post_reti, cur_src};
          default:           reg_rdata_o <= `VIC_RST_BYTE;
        endcase
      end
    end
  end

  // Checks on the controller's own behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_global_gate: assert property (
    ce_i && !interrupt_enable_main[`VIC_IE_GLOBAL] |=> !det_valid)
    else $error("request detected with global enable off");

  a_high_no_preempt: assert property (
    accept |-> !in_svc_hi)
    else $error("running high routine was preempted");

  a_equal_blocked: assert property (
    accept && !det_hi |-> !in_svc_lo)
    else $error("low request entered over running low routine");

  a_call_latency: assert property (
    (accept && ce_i) ##1 ce_i [*4] |=> vector_valid_o)
    else $error("vector not issued four clocks after acceptance");

  a_edge_autoclear: assert property (
    accept && det_src == `VIC_SRC_EXT0 && type0_edge && !ext0_fall
      |=> !flags[`VIC_SRC_EXT0])
    else $error("edge flag not cleared on vectoring");

  a_level_mirror: assert property (
    (ce_i && !type0_edge && !ext_request_zero_n_i) [*3]
      |-> pend_eff[`VIC_SRC_EXT0])
    else $error("level pending does not follow the pin");

  a_reti_one_more: assert property (
    ce_i && core_i.instr_done && core_i.reti_done
      ##1 (core_i.instr_done && ce_i) |-> !accept)
    else $error("request taken without one instruction after return");

  a_page_select: assert property (
    vector_valid_o && $past(auto_page_switch_enable)
      |-> register_page_select_o == page_of(cur_src))
    else $error("register page does not match the vectored source");

  a_high_wins: assert property (
    ce_i && (|req_hi) |=> det_hi && (($past(req_hi) >> det_src) & 21'h1) != 21'h0
      && ($past(req_hi) & ~({21{1'b1}} << det_src)) == 21'h0)
    else $error("high level request lost arbitration");

endmodule : vic_top

//--- tb/test_vectored_interrupt_controller.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_vectored_interrupt_controller
  import vic_pkg::*;
;
  logic        clk, rst, we, re, ext0_n, ext1_n, slow, ret_req, call, vv;
  logic [7:0]  addr, wd, rdata, page, d;
  logic [15:0] vec;
  logic        ce;
  vic_events_s evts;
  vic_flags_s  flags;
  vic_core_s   core;
  int          err_total, tests_run;

  // Design and core model
  vic_top i_dut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .ext_request_zero_n_i(ext0_n),
    .ext_request_one_n_i(ext1_n), .periph_flags_i(flags),
    .periph_events_i(evts), .core_i(core), .call_active_o(call),
    .vector_valid_o(vv), .vector_o(vec), .register_page_select_o(page));
  vic_core_model i_core (.core_clk_i(clk),
    .rst_i(rst), .slow_i(slow), .ret_req_i(ret_req), .call_active_i(call),
    .core_o(core));

  // System clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd   <= v;
    we   <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 `CHK("read data", e, rdata)
  endtask : rchk

  // Wait for a vector pulse, check target and optionally the edge count
  task automatic vchk(input logic [15:0] e, input int kx);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (vv !== 1'b1 && k < 60);
    `CHK("vector pulse", 1'b1, vv)
    `CHK("vector", e, vec)
    if (kx > 0) `CHK("latency", kx, k)
  endtask : vchk

  // No vector may appear for twenty cycles
  task automatic quiet();
    int k;
    k = 0;
    repeat (20) begin
      @(posedge clk);
      #1 if (vv === 1'b1) k++;
    end
    `CHK("no call", 0, k)
  endtask : quiet

  task automatic ret();
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask : ret

  task automatic setf(input logic s0, input logic t2);
    @(posedge clk);
    flags.serial_zero <= {s0, 1'b0};
    flags.timer_two   <= t2;
  endtask : setf

  task automatic t_regs();
    rchk(8'hb8, 8'hc0);
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h40);
    ce <= 1'b0;
    wr(8'ha8, 8'h11);
    ce <= 1'b1;
    rchk(8'ha8, 8'h40);
    rchk(8'h00, 8'h00);
    $display("end of regs, mismatches %0d", err_total);
  endtask : t_regs

  task automatic t_vectors();
    logic [15:0] ev;
    logic [7:0]  pm;
    wr(8'ha8, 8'hbf);
    wr(8'he6, 8'h7f);
    wr(8'he7, 8'h7f);
    wr(8'h8f, 8'h01);
    for (int s = 1; s < 21; s++) begin
      if (s == 2 || s == 13) continue;
      ev = (s == 17) ? 16'h0093 : (s == 18) ? 16'h008b : 16'(3 + 8 * s);
      pm = (s == 12) ? 8'h03 : (s inside {10, 14, 19, 20}) ? 8'h01 :
           (s inside {11, 16, 17, 18}) ? 8'h02 : 8'h00;
      wr(8'hd8 + 8'(s / 8), 8'h01 << (s % 8));
      vchk(ev, 6);
      `CHK("page", pm, page)
      @(posedge clk);
      addr <= 8'hd8 + 8'(s / 8);
      re   <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 `CHK("flag", (s inside {1, 3, 19}) ? 1'b0 : 1'b1, rdata[s % 8])
      wr(8'hd8 + 8'(s / 8), 8'h00);
      ret();
    end
    $display("end of vectors, mismatches %0d", err_total);
  endtask : t_vectors

  task automatic t_prio();
    wr(8'he6, 8'h00);
    wr(8'he7, 8'h00);
    setf(1'b1, 1'b1);
    vchk(16'h0023, 0);
    wr(8'hb8, 8'h20);
    vchk(16'h002b, 0);
    quiet();
    setf(1'b1, 1'b0);
    ret();
    quiet();
    wr(8'hb8, 8'h00);
    setf(1'b0, 1'b1);
    ret();
    vchk(16'h002b, 7);
    setf(1'b0, 1'b0);
    ret();
    $display("end of priority, mismatches %0d", err_total);
  endtask : t_prio

  task automatic t_global();
    @(posedge clk);
    slow <= 1'b1;
    wr(8'ha8, 8'h7f);
    setf(1'b0, 1'b1);
    quiet();
    wr(8'ha8, 8'h80);
    quiet();
    wr(8'ha8, 8'ha0);
    vchk(16'h002b, 0);
    setf(1'b0, 1'b0);
    slow <= 1'b0;
    ret();
    ret();
    $display("end of global, mismatches %0d", err_total);
  endtask : t_global

  task automatic t_ext();
    wr(8'h88, 8'h05);
    wr(8'ha8, 8'h85);
    @(posedge clk);
    ext0_n <= 1'b0;
    vchk(16'h0003, 0);
    rchk(8'h88, 8'h05);
    @(posedge clk);
    ext0_n <= 1'b1;
    ret();
    wr(8'h88, 8'h00);
    @(posedge clk);
    ext1_n <= 1'b0;
    vchk(16'h0013, 0);
    rchk(8'h88, 8'h08);
    @(posedge clk);
    ext1_n <= 1'b1;
    repeat (3) @(posedge clk);
    ret();
    rchk(8'h88, 8'h00);
    quiet();
    @(posedge clk);
    ext0_n <= 1'b0;
    vchk(16'h0003, 0);
    rchk(8'h88, 8'h02);
    @(posedge clk);
    ext0_n <= 1'b1;
    repeat (3) @(posedge clk);
    ret();
    @(posedge clk);
    evts.timer_zero_ovf <= 1'b1;
    @(posedge clk);
    evts.timer_zero_ovf <= 1'b0;
    rchk(8'h88, 8'h20);
    $display("end of external, mismatches %0d", err_total);
  endtask : t_ext

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Main sequence after six reset cycles
  initial begin
    rst = 1'b1;
    {we, re, slow, ret_req} = 4'h0;
    {addr, wd} = 16'h0000;
    {ext0_n, ext1_n} = 2'b11;
    flags = '0;
    evts = '0;
    ce = 1'b1;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_vectors();
    t_prio();
    t_global();
    t_ext();
    tally_and_finish();
  end

  // Watchdog well past the expected run length
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule : test_vectored_interrupt_controller

//--- tb/vic_core_model.sv
// Core sequencer model giving instruction boundaries and returns
`timescale 1ns/1ns
module vic_core_model
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Bench controls: slow pacing, one-cycle return request
  input  wire logic slow_i,
  input  wire logic ret_req_i,
  // Link to the controller
  input  wire logic call_active_i,
  output vic_core_s core_o
);
  logic [1:0] gap;

  // Instructions end every cycle, or every third when slow; none in a call
  always_ff @(posedge core_clk_i) begin
    if (rst_i || call_active_i) begin
      gap    <= 2'h0;
      core_o <= '0;
    end else begin
      gap               <= (!slow_i || gap == 2'h2) ? 2'h0 : gap + 2'h1;
      core_o.instr_done <= (gap == 2'h0);
      core_o.reti_done  <= (gap == 2'h0) && ret_req_i;
    end
  end
endmodule : vic_core_model
